// >>> protocol_snoop_trap_control.v
// Purpose : protocol snoop/trap stage between ingress parser and forwarding
// Assumes : parser and forwarding logic run on mclk; one header per frame_valid
// Notes   : decision appears one mclk after frame_valid; registers on AXI4-Lite
//
// What this block does
// - IGMP report/leave goes to CPU only when bit 10 set, else L2 plus copy.
// - bit 9 enables IGMP report/leave special handling.
// - with destination check on, IGMP needs protocol 2 and a class D address.
// - bit 5 set traps non-MLD ICMPv6 to CPU, else L2 plus copy.
// - bit 4 enables ICMPv6 handling; next header 58 marks ICMPv6.
// - next header 0 followed by extension next header 58 is ICMPv6 too.
// - bit 3 adds a CPU copy to ICMPv4 frames.
// - bit 2 adds a CPU copy to DHCP frames.
// - bit 1 adds a CPU copy to RARP frames.
// - bit 0 adds a CPU copy to ARP frames.
// - bits 11 to 18 give MLD and IGMP query/unknown enable and mode.

`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.vh"

module protocol_snoop_trap_control #(
  parameter NUM_PORTS = 9,
  parameter CPU_PORT  = 8
) (
  // clock and reset
  input  wire                  mclk,
  input  wire                  arst_n,

  // axi4-lite write address
  input  wire [11:0]           s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,

  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,

  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,

  // axi4-lite read address
  input  wire [11:0]           s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,

  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,

  // parsed frame header from ingress parser
  input  wire                  frame_valid,
  input  wire [15:0]           eth_type,
  input  wire [7:0]            ip_proto,
  input  wire [7:0]            ip6_next_hdr,
  input  wire [7:0]            ip6_ext_next_hdr,
  input  wire [31:0]           dest_ip,
  input  wire [15:0]           udp_src_port,
  input  wire [15:0]           udp_dst_port,
  input  wire [7:0]            igmp_type,
  input  wire [7:0]            icmp6_type,

  // l2 lookup result for the same frame
  input  wire [NUM_PORTS-1:0]  l2_port_map,

  // forwarding decision
  output reg                   fwd_valid,
  output reg  [NUM_PORTS-1:0]  fwd_port_map,
  output reg                   fwd_cpu_copy,
  output reg                   fwd_cpu_trap,
  output reg  [`CLASS_WIDTH-1:0] fwd_class
);

  // ==========================================================================
  // response codes and helpers
  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  // merge bytes of a write into an old word under the strobes
  function [31:0] strobe_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    integer      i;

    begin
      strobe_merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strobe_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // word address compare, low two bits ignored
  function addr_is;
    input [11:0] addr;
    input [11:0] target;

    begin
      addr_is = (addr[11:2] == target[11:2]);
    end
  endfunction

  // ==========================================================================
  // register storage
  reg  [31:0]              ctrl;
  reg  [15:0]              cpu_frame_count;
  reg  [`CLASS_WIDTH-1:0]  last_class;
  wire [31:0]              status_word;

  // ==========================================================================
  // write channel holding registers
  reg         aw_held;
  reg  [11:0] aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire        aw_fire;
  wire        w_fire;
  wire        wr_have_addr;
  wire        wr_have_data;
  wire        wr_do;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;

  // each channel taken once, then stalled until the response is gone
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // handshake strobes
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;

  // the write may complete in the very cycle both halves arrive
  assign wr_have_addr = aw_held || aw_fire;
  assign wr_have_data = w_held || w_fire;
  assign wr_do        = wr_have_addr && wr_have_data && !s_axi_bvalid;

  // held copy wins
  assign wr_addr      = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data      = w_held ? w_data : s_axi_wdata;
  assign wr_strb      = w_held ? w_strb : s_axi_wstrb;

  // address half, in either order with data
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  // data half
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (wr_do) begin
      w_held <= 1'b0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // ==========================================================================
  // control register
  // upper mode bits stored alongside
  // reserved bits masked so they always read as zero
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `SNOOP_CTRL_RESET;
    end else if (wr_do && addr_is(wr_addr, `SNOOP_CTRL_OFFSET)) begin
      ctrl <= strobe_merge(ctrl, wr_data, wr_strb) & `SNOOP_CTRL_WR_MASK;
    end
  end

  // write response; unmapped or read-only targets answer slverr
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_is(wr_addr, `SNOOP_CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // released once taken
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel
  // read strobe
  wire ar_fire;

  // one read in flight; next address taken once data has left
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  // status shows last class seen and the cpu-bound frame count
  assign status_word = {cpu_frame_count, {(16-`CLASS_WIDTH){1'b0}}, last_class};

  // read data registered, one cycle after the address is taken
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      if (addr_is(s_axi_araddr, `SNOOP_CTRL_OFFSET)) begin
        s_axi_rdata <= ctrl;
        s_axi_rresp <= RESP_OKAY;
      end else if (addr_is(s_axi_araddr, `SNOOP_STATUS_OFFSET)) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        // unmapped: slverr
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // frame classification
  wire [`CLASS_WIDTH-1:0] class_hot;
  wire                    cpu_copy;
  wire                    cpu_trap;

  snoop_classify u_classify (
    .eth_type         (eth_type),
    .ip_proto         (ip_proto),
    .ip6_next_hdr     (ip6_next_hdr),
    .ip6_ext_next_hdr (ip6_ext_next_hdr),
    .dest_ip          (dest_ip),
    .udp_src_port     (udp_src_port),
    .udp_dst_port     (udp_dst_port),
    .igmp_type        (igmp_type),
    .icmp6_type       (icmp6_type),
    .dip_check        (ctrl[`IGMP_DEST_IP_CHECK_BIT]),
    .class_hot        (class_hot)
  );

  // copy or trap
  snoop_action u_action (
    .class_hot (class_hot),
    .ctrl      (ctrl),
    .cpu_copy  (cpu_copy),
    .cpu_trap  (cpu_trap)
  );

  // ==========================================================================
  // port map shaping
  wire [NUM_PORTS-1:0] cpu_only;
  reg  [NUM_PORTS-1:0] next_port_map;

  // one-hot cpu port mask
  assign cpu_only = {{(NUM_PORTS-1){1'b0}}, 1'b1} << CPU_PORT;

  // trap replaces the l2 map, copy adds the cpu port to it
  always @* begin
    next_port_map = l2_port_map;
    if (cpu_trap) begin
      next_port_map = cpu_only;
    end
    else if (cpu_copy) begin
      next_port_map = l2_port_map | cpu_only;
    end
  end

  // decision registered so forwarding sees a clean, aligned result
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_valid    <= 1'b0;
      fwd_port_map <= {NUM_PORTS{1'b0}};
      fwd_cpu_copy <= 1'b0;
      fwd_cpu_trap <= 1'b0;
      fwd_class    <= {`CLASS_WIDTH{1'b0}};
    end else begin
      fwd_valid <= frame_valid;
      // idle: hold decision
      if (frame_valid) begin
        fwd_port_map <= next_port_map;
        fwd_cpu_copy <= cpu_copy;
        fwd_cpu_trap <= cpu_trap;
        fwd_class    <= class_hot;
      end
    end
  end

  // ==========================================================================
  // status tracking
  // count saturates so software never sees a wrap as a drop
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_frame_count <= 16'h0000;
      last_class      <= {`CLASS_WIDTH{1'b0}};
    end else if (frame_valid) begin
      // zero class: keep
      if (class_hot != {`CLASS_WIDTH{1'b0}}) begin
        last_class <= class_hot;
      end
      if ((cpu_copy || cpu_trap) && (cpu_frame_count != 16'hFFFF)) begin
        cpu_frame_count <= cpu_frame_count + 16'h0001;
      end
    end
  end

  // protection bits are accepted but do not gate access
  wire unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule // protocol_snoop_trap_control

`default_nettype wire

// >>> snoop_regs.vh
// Purpose : register map, field positions and protocol constants of the snoop/trap block
// Assumes : included by bare name from every design file of the block
// Notes   : definitions only
`ifndef SNOOP_REGS_VH
`define SNOOP_REGS_VH

// ==========================================================================
// register offsets and reset values
`define SNOOP_CTRL_OFFSET      12'h050
`define SNOOP_STATUS_OFFSET    12'h054
`define SNOOP_CTRL_RESET       32'h00000000
`define SNOOP_CTRL_WR_MASK     32'h0007FF3F

// ==========================================================================
// control field positions
`define ARP_SNOOP_ENABLE_BIT        0
`define RARP_SNOOP_ENABLE_BIT       1
`define DHCP_SNOOP_ENABLE_BIT       2
`define ICMP4_SNOOP_ENABLE_BIT      3
`define ICMP6_SNOOP_ENABLE_BIT      4
`define ICMP6_TRAP_ONLY_BIT         5
`define IGMP_DEST_IP_CHECK_BIT      8
`define IGMP_RPTLVE_ENABLE_BIT      9
`define IGMP_RPTLVE_TRAP_ONLY_BIT   10
`define IGMP_QUERY_ENABLE_BIT       11
`define IGMP_QUERY_TRAP_ONLY_BIT    12
`define IGMP_UNKNOWN_ENABLE_BIT     13
`define IGMP_UNKNOWN_TRAP_ONLY_BIT  14
`define MLD_RPTDONE_ENABLE_BIT      15
`define MLD_RPTDONE_TRAP_ONLY_BIT   16
`define MLD_QUERY_ENABLE_BIT        17
`define MLD_QUERY_TRAP_ONLY_BIT     18

// ==========================================================================
// class one-hot positions
`define CLASS_WIDTH        10
`define CLS_ARP            0
`define CLS_RARP           1
`define CLS_DHCP           2
`define CLS_ICMP4          3
`define CLS_ICMP6          4
`define CLS_IGMP_RPTLVE    5
`define CLS_IGMP_QUERY     6
`define CLS_IGMP_UNKNOWN   7
`define CLS_MLD_RPTDONE    8
`define CLS_MLD_QUERY      9

// ==========================================================================
// protocol values
`define ETYPE_IPV4      16'h0800
`define ETYPE_IPV6      16'h86DD
`define ETYPE_ARP       16'h0806
`define ETYPE_RARP      16'h8035
`define IPPROTO_ICMP4   8'h01
`define IPPROTO_IGMP    8'h02
`define IPPROTO_UDP     8'h11
`define NEXTHDR_HOPOPT  8'h00
`define NEXTHDR_ICMP6   8'h3A
`define CLASS_D_PREFIX  4'hE
`define DHCP_PORT_SRV   16'h0043
`define DHCP_PORT_CLI   16'h0044
`define IGMP_T_QUERY    8'h11
`define IGMP_T_V1_RPT   8'h12
`define IGMP_T_V2_RPT   8'h16
`define IGMP_T_LEAVE    8'h17
`define IGMP_T_V3_RPT   8'h22
`define MLD_T_QUERY     8'h82
`define MLD_T_V1_RPT    8'h83
`define MLD_T_DONE      8'h84
`define MLD_T_V2_RPT    8'h8F

`endif

// >>> snoop_classify.v
// Purpose : sort one parsed frame header into a snoop class
// Assumes : header fields are valid while the parser presents them
// Notes   : purely combinational; classes are mutually exclusive
`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.vh"

module snoop_classify (
  // parsed header fields
  input  wire [15:0]              eth_type,
  input  wire [7:0]               ip_proto,
  input  wire [7:0]               ip6_next_hdr,
  input  wire [7:0]               ip6_ext_next_hdr,
  input  wire [31:0]              dest_ip,
  input  wire [15:0]              udp_src_port,
  input  wire [15:0]              udp_dst_port,
  input  wire [7:0]               igmp_type,
  input  wire [7:0]               icmp6_type,
  // configuration
  input  wire                     dip_check,
  // result
  output reg  [`CLASS_WIDTH-1:0]  class_hot
);

  wire is_ip4;
  wire is_ip6;
  wire igmp_hit;
  wire icmp6_hit;
  wire mld_query;
  wire mld_report;
  wire igmp_query;
  wire igmp_report;

  assign is_ip4 = (eth_type == `ETYPE_IPV4);
  assign is_ip6 = (eth_type == `ETYPE_IPV6);

  assign igmp_hit = is_ip4 && (ip_proto == `IPPROTO_IGMP) &&
                    (!dip_check || (dest_ip[31:28] == `CLASS_D_PREFIX));

  assign icmp6_hit = is_ip6 && ((ip6_next_hdr == `NEXTHDR_ICMP6) ||
                     ((ip6_next_hdr == `NEXTHDR_HOPOPT) && (ip6_ext_next_hdr == `NEXTHDR_ICMP6)));

  assign mld_query   = (icmp6_type == `MLD_T_QUERY);
  assign mld_report  = (icmp6_type == `MLD_T_V1_RPT) || (icmp6_type == `MLD_T_DONE) ||
                       (icmp6_type == `MLD_T_V2_RPT);
  assign igmp_query  = (igmp_type == `IGMP_T_QUERY);
  assign igmp_report = (igmp_type == `IGMP_T_V1_RPT) || (igmp_type == `IGMP_T_V2_RPT) ||
                       (igmp_type == `IGMP_T_LEAVE) || (igmp_type == `IGMP_T_V3_RPT);

  // one-hot class vector
  always @* begin
    class_hot                    = {`CLASS_WIDTH{1'b0}};
    class_hot[`CLS_ARP]          = (eth_type == `ETYPE_ARP);
    class_hot[`CLS_RARP]         = (eth_type == `ETYPE_RARP);
    class_hot[`CLS_DHCP]         = is_ip4 && (ip_proto == `IPPROTO_UDP) &&
                                   ((udp_dst_port == `DHCP_PORT_SRV) || (udp_dst_port == `DHCP_PORT_CLI)) &&
                                   ((udp_src_port == `DHCP_PORT_SRV) || (udp_src_port == `DHCP_PORT_CLI));
    class_hot[`CLS_ICMP4]        = is_ip4 && (ip_proto == `IPPROTO_ICMP4);
    class_hot[`CLS_ICMP6]        = icmp6_hit && !mld_query && !mld_report;
    class_hot[`CLS_MLD_QUERY]    = icmp6_hit && mld_query;
    class_hot[`CLS_MLD_RPTDONE]  = icmp6_hit && mld_report;
    class_hot[`CLS_IGMP_RPTLVE]  = igmp_hit && igmp_report;
    class_hot[`CLS_IGMP_QUERY]   = igmp_hit && igmp_query;
    class_hot[`CLS_IGMP_UNKNOWN] = igmp_hit && !igmp_report && !igmp_query;
  end

endmodule // snoop_classify
`default_nettype wire

// >>> snoop_action.v
// Purpose : turn a frame class and the control word into copy/trap decisions
// Assumes : at most one class bit set
// Notes   : combinational
`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.vh"

module snoop_action (
  // inputs
  input  wire [`CLASS_WIDTH-1:0]  class_hot,
  input  wire [31:0]              ctrl,
  // decision
  output reg                      cpu_copy,
  output reg                      cpu_trap
);

  // {trap, copy}; a disabled class yields nothing special
  function [1:0] act;
    input en;
    input trap_only;
    begin
      act = en ? (trap_only ? 2'b10 : 2'b01) : 2'b00;
    end
  endfunction

  reg [1:0] sel;

  // mode bits count only when enabled
  always @* begin
    sel = 2'b00;
    if (class_hot[`CLS_ARP])
      sel = act(ctrl[`ARP_SNOOP_ENABLE_BIT], 1'b0);
    if (class_hot[`CLS_RARP])
      sel = act(ctrl[`RARP_SNOOP_ENABLE_BIT], 1'b0);
    if (class_hot[`CLS_DHCP])
      sel = act(ctrl[`DHCP_SNOOP_ENABLE_BIT], 1'b0);
    if (class_hot[`CLS_ICMP4])
      sel = act(ctrl[`ICMP4_SNOOP_ENABLE_BIT], 1'b0);
    if (class_hot[`CLS_ICMP6])
      sel = act(ctrl[`ICMP6_SNOOP_ENABLE_BIT], ctrl[`ICMP6_TRAP_ONLY_BIT]);
    if (class_hot[`CLS_IGMP_RPTLVE])
      sel = act(ctrl[`IGMP_RPTLVE_ENABLE_BIT], ctrl[`IGMP_RPTLVE_TRAP_ONLY_BIT]);
    if (class_hot[`CLS_IGMP_QUERY])
      sel = act(ctrl[`IGMP_QUERY_ENABLE_BIT], ctrl[`IGMP_QUERY_TRAP_ONLY_BIT]);
    if (class_hot[`CLS_IGMP_UNKNOWN])
      sel = act(ctrl[`IGMP_UNKNOWN_ENABLE_BIT], ctrl[`IGMP_UNKNOWN_TRAP_ONLY_BIT]);
    if (class_hot[`CLS_MLD_RPTDONE])
      sel = act(ctrl[`MLD_RPTDONE_ENABLE_BIT], ctrl[`MLD_RPTDONE_TRAP_ONLY_BIT]);
    if (class_hot[`CLS_MLD_QUERY])
      sel = act(ctrl[`MLD_QUERY_ENABLE_BIT], ctrl[`MLD_QUERY_TRAP_ONLY_BIT]);
    cpu_trap = sel[1];
    cpu_copy = sel[0];
  end

endmodule // snoop_action
`default_nettype wire

// >>> protocol_snoop_trap_control_chk.sv
// Purpose : port-level checks of the snoop/trap stage
// Assumes : bound to protocol_snoop_trap_control
// Notes   : decision lands one mclk after frame_valid
`timescale 1ns/100ps
`default_nettype none

module protocol_snoop_trap_control_chk #(
  parameter NUM_PORTS = 9,
  parameter CPU_PORT  = 8
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 arst_n,
  // frame path
  input wire logic                 frame_valid,
  input wire logic [NUM_PORTS-1:0] l2_port_map,
  input wire logic                 fwd_valid,
  input wire logic [NUM_PORTS-1:0] fwd_port_map,
  input wire logic                 fwd_cpu_copy,
  input wire logic                 fwd_cpu_trap,
  input wire logic [9:0]           fwd_class
);
  localparam [NUM_PORTS-1:0] CPU_BIT = {{(NUM_PORTS-1){1'b0}}, 1'b1} << CPU_PORT;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  AST_FWD_LATENCY: assert property (frame_valid |=> fwd_valid)
    else $error("no decision one cycle after frame");
  AST_TRAP_MAP: assert property (fwd_valid && fwd_cpu_trap |-> fwd_port_map == CPU_BIT)
    else $error("trap map is not cpu port alone");
  AST_COPY_MAP: assert property (fwd_valid && fwd_cpu_copy |-> fwd_port_map == ($past(l2_port_map) | CPU_BIT))
    else $error("copy map is not l2 plus cpu");
  AST_PLAIN_MAP: assert property (fwd_valid && !fwd_cpu_copy && !fwd_cpu_trap |-> fwd_port_map == $past(l2_port_map))
    else $error("plain map differs from l2 map");
  AST_ONE_ACTION: assert property (fwd_valid |-> !(fwd_cpu_copy && fwd_cpu_trap))
    else $error("copy and trap together");
  AST_CLASS_ONEHOT: assert property (fwd_valid |-> $onehot0(fwd_class))
    else $error("class not one-hot");
  AST_NO_TRAP_L2: assert property (fwd_valid && |fwd_class[3:0] |-> !fwd_cpu_trap)
    else $error("trap on a copy-only class");
  AST_NONE_PLAIN: assert property (fwd_valid && fwd_class == 10'h000 |-> !fwd_cpu_copy && !fwd_cpu_trap)
    else $error("action on unclassified frame");

  // main scenarios seen
  COV_TRAP: cover property (fwd_valid && fwd_cpu_trap);
  COV_COPY: cover property (fwd_valid && fwd_cpu_copy);
  COV_B2B: cover property (fwd_valid [*2]);
endmodule // protocol_snoop_trap_control_chk

`default_nettype wire

// >>> protocol_snoop_trap_control_tb.sv
// Purpose : self-checking bench of the snoop/trap stage
// Assumes : bench is AXI4-Lite master and parser
// Notes   : fixed-seed xorshift stimulus with corner tables
`timescale 1ns/100ps
`default_nettype none
`include "snoop_regs.vh"

// one counted compare
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end

module protocol_snoop_trap_control_tb;
  typedef struct packed {
    logic [15:0] et;
    logic [7:0]  pr, nh, ex;
    logic [31:0] dip;
    logic [15:0] sp, dp;
    logic [7:0]  it, t6;
    logic [8:0]  l2;
  } hdr_t;

  // ==========================================================================
  // drive and observe
  logic        mclk = 0, arst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, dest_ip = 0;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, frame_valid = 0;
  logic [15:0] eth_type = 0, udp_src_port = 0, udp_dst_port = 0;
  logic [7:0]  ip_proto = 0, ip6_next_hdr = 0, ip6_ext_next_hdr = 0, igmp_type = 0, icmp6_type = 0;
  logic [8:0]  l2_port_map = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         fwd_valid, fwd_cpu_copy, fwd_cpu_trap;
  wire [8:0]   fwd_port_map;
  wire [9:0]   fwd_class;
  // bench state and corner tables
  int          err_total = 0, num_checks = 0, cnt = 0;
  logic [31:0] seed = 32'h6A88B2D6, ctrl = 0, rd;
  logic [1:0]  rs;
  logic [9:0]  last_cls = 0;
  logic [21:0] q[$];
  logic [21:0] held = 0;
  int          en_bit[10] = '{0, 1, 2, 3, 4, 9, 11, 13, 15, 17};
  logic [7:0]  igmp_tab[8] = '{8'h11, 8'h12, 8'h16, 8'h17, 8'h22, 8'h13, 8'h00, 8'hFF};
  logic [7:0]  t6_tab[8] = '{8'h82, 8'h83, 8'h84, 8'h8F, 8'h80, 8'h81, 8'h87, 8'h3A};
  logic [31:0] dip_tab[4] = '{32'hE0000000, 32'hEFFFFFFF, 32'hDFFFFFFF, 32'hF0000000};
  logic [31:0] ctrl_tab[4] = '{32'h00000000, 32'hFFFFFFFF, 32'h0002AA1F, 32'h00055420};

  protocol_snoop_trap_control #(.NUM_PORTS(9), .CPU_PORT(8)) i_dut (.*);

  // 50 ns clock
  initial forever #25 mclk = ~mclk;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {valid, class, map, copy, trap} of one header
  function automatic logic [21:0] exp_out(hdr_t h, logic [31:0] c);
    logic [9:0] k;
    logic       cp, tr;
    k = 10'h000;
    cp = 0;
    tr = 0;
    if (h.et == `ETYPE_ARP) k[0] = 1;
    else if (h.et == `ETYPE_RARP) k[1] = 1;
    else if (h.et == `ETYPE_IPV4) begin
      if (h.pr == `IPPROTO_UDP && (h.sp == `DHCP_PORT_SRV || h.sp == `DHCP_PORT_CLI)
          && (h.dp == `DHCP_PORT_SRV || h.dp == `DHCP_PORT_CLI)) k[2] = 1;
      else if (h.pr == `IPPROTO_ICMP4) k[3] = 1;
      else if (h.pr == `IPPROTO_IGMP && (!c[8] || h.dip[31:28] == `CLASS_D_PREFIX)) begin
        if (h.it == 8'h12 || h.it == 8'h16 || h.it == 8'h17 || h.it == 8'h22) k[5] = 1;
        else if (h.it == `IGMP_T_QUERY) k[6] = 1;
        else k[7] = 1;
      end
    end else if (h.et == `ETYPE_IPV6 && (h.nh == 8'h3A || (h.nh == 8'h00 && h.ex == 8'h3A))) begin
      if (h.t6 == 8'h82) k[9] = 1;
      else if (h.t6 == 8'h83 || h.t6 == 8'h84 || h.t6 == 8'h8F) k[8] = 1;
      else k[4] = 1;
    end
    // mode bit sits just above its enable; low four classes copy only
    for (int b = 0; b < 10; b++)
      if (k[b] && c[en_bit[b]]) begin
        if (b > 3 && c[en_bit[b] + 1]) tr = 1;
        else cp = 1;
      end
    return {1'b1, k, tr ? 9'h100 : h.l2 | {cp, 8'h00}, cp, tr};
  endfunction

  // one write, full word
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    rs = s_axi_bresp;
    `CHK(n < 40, 1'b1)
  endtask

  // one read into rd and rs
  task automatic axi_rd(input logic [11:0] a);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    `CHK(n < 40, 1'b1)
  endtask

  // back-to-back headers, gaps at random; checks trail by two edges
  task automatic run_frames(input int n);
    hdr_t         h;
    logic [31:0]  r;
    logic [159:0] t;
    logic [21:0]  e;
    for (int i = 0; i < n + 2; i++) begin
      @(posedge mclk);
      if (i >= 2) begin
        e = q.pop_front();
        `CHK({fwd_valid, fwd_class, fwd_port_map, fwd_cpu_copy, fwd_cpu_trap}, e)
      end
      r = rnd();
      t = {rnd(), rnd(), rnd(), rnd(), rnd()};
      h = t[128:0];
      case (r[3:0])
        0: h.et = `ETYPE_ARP;
        1: h.et = `ETYPE_RARP;
        2: begin
          h.et = `ETYPE_IPV4;
          h.pr = `IPPROTO_UDP;
          h.sp = r[4] ? `DHCP_PORT_SRV : `DHCP_PORT_CLI;
          h.dp = r[5] ? `DHCP_PORT_SRV : r[6] ? `DHCP_PORT_CLI : 16'h0045;
        end
        3: begin
          h.et = `ETYPE_IPV4;
          h.pr = `IPPROTO_ICMP4;
        end
        4, 5: begin
          h.et = `ETYPE_IPV4;
          h.pr = `IPPROTO_IGMP;
          h.it = igmp_tab[r[7:5]];
          h.dip = dip_tab[r[9:8]];
        end
        6, 7: begin
          h.et = `ETYPE_IPV6;
          h.nh = r[0] ? 8'h00 : 8'h3A;
          h.ex = r[4] ? 8'h3A : 8'h3B;
          h.t6 = t6_tab[r[7:5]];
        end
        default: ;
      endcase
      {eth_type, ip_proto, ip6_next_hdr, ip6_ext_next_hdr, dest_ip, udp_src_port, udp_dst_port,
       igmp_type, icmp6_type, l2_port_map} <= h;
      if (i >= n || r[12:11] == 2'h0) begin
        frame_valid <= 0;
        q.push_back({1'b0, held[20:0]});
      end else begin
        frame_valid <= 1;
        held = exp_out(h, ctrl & `SNOOP_CTRL_WR_MASK);
        q.push_back(held);
        cnt += held[1] | held[0];
        if (held[20:11] != 10'h000) last_cls = held[20:11];
      end
    end
    q.delete();
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1;
    axi_rd(`SNOOP_CTRL_OFFSET);
    `CHK({rs, rd}, {2'b00, `SNOOP_CTRL_RESET})
    // refused places leave control alone
    axi_wr(`SNOOP_STATUS_OFFSET, 32'hFFFFFFFF);
    `CHK(rs, 2'b10)
    axi_wr(12'h200, 32'hFFFFFFFF);
    `CHK(rs, 2'b10)
    axi_rd(12'h3FC);
    `CHK({rs, rd}, {2'b10, 32'h00000000})
    // fixed corners first, then random control words
    for (int k = 0; k < 10; k++) begin
      ctrl = k < 4 ? ctrl_tab[k] : rnd();
      axi_wr(`SNOOP_CTRL_OFFSET, ctrl);
      axi_rd(`SNOOP_CTRL_OFFSET);
      `CHK({rs, rd}, {2'b00, ctrl & `SNOOP_CTRL_WR_MASK})
      run_frames(64);
    end
    axi_rd(`SNOOP_STATUS_OFFSET);
    `CHK({rs, rd[31:16], rd[9:0]}, {2'b00, cnt[15:0], last_cls})
    print_verdict();
  end

  // watchdog, several times the planned run
  initial begin
    #(50 * 4000);
    $display("mismatch t=%0t timeout", $time);
    err_total++;
    print_verdict();
  end
endmodule // protocol_snoop_trap_control_tb

bind protocol_snoop_trap_control protocol_snoop_trap_control_chk #(
  .NUM_PORTS(NUM_PORTS), .CPU_PORT(CPU_PORT)) u_chk (.*);

`default_nettype wire
